// ---- design/sfs_pkg.sv ----
// Package with the register map, selection codes and timing of the selector
`default_nettype none
package sfs_pkg;
	// Register byte offsets on the APB port
	localparam logic [7:0] SEL_OFS = 8'h00;
	localparam logic [7:0] SEQ_OFS = 8'h04;
	localparam logic [7:0] SET_COUNT_OFS = 8'h08;
	localparam logic [7:0] SPEC_COUNT_OFS = 8'h0C;
	localparam logic [7:0] SET_LENGTH_OFS = 8'h10;
	localparam logic [7:0] OVL_COEFF_OFS = 8'h14;
	localparam logic [7:0] PROC_UPPER_OFS = 8'h18;
	localparam logic [7:0] PROC_LOWER_OFS = 8'h1C;
	localparam logic [7:0] ADT_ONE_OFS = 8'h20;
	localparam logic [7:0] ADT_TWO_OFS = 8'h24;
	localparam logic [7:0] UV_STALL_OFS = 8'h28;
	localparam logic [7:0] RECOVERY_LVL_OFS = 8'h2C;
	localparam logic [7:0] RECOVERY_DLY_OFS = 8'h30;
	localparam logic [7:0] RUN_TIME_OFS = 8'h34;
	localparam logic [7:0] ZERO_SERVO_OFS = 8'h38;
	localparam logic [7:0] SW_WORD_OFS = 8'h3C;
	localparam logic [7:0] CUR_TARGET_OFS = 8'h40;
	localparam logic [7:0] TORQ_TARGET_OFS = 8'h44;
	localparam logic [7:0] STATUS_OFS = 8'h48;
	// Field positions
	localparam int SEL_OC_LSB = 0;
	localparam int SEL_RLY_LSB = 8;
	localparam int SEL_W = 7;
	localparam int SEQ_LIMIT_LSB = 16;
	localparam int HYST_LSB = 16;
	localparam int SW_OC_BIT = 0;
	localparam int SW_RLY_BIT = 1;
	// Reset values
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	// Selection codes handled here
	localparam logic [6:0] CODE_SEQ_DONE = 7'h0D;
	localparam logic [6:0] CODE_SET_COUNT = 7'h0E;
	localparam logic [6:0] CODE_SPEC_COUNT = 7'h0F;
	localparam logic [6:0] CODE_LENGTH = 7'h10;
	localparam logic [6:0] CODE_OVERLOAD = 7'h11;
	localparam logic [6:0] CODE_OVERHEAT = 7'h12;
	localparam logic [6:0] CODE_PROC_HIGH = 7'h13;
	localparam logic [6:0] CODE_PROC_LOW = 7'h14;
	localparam logic [6:0] CODE_ADT_ONE = 7'h15;
	localparam logic [6:0] CODE_ADT_TWO = 7'h16;
	localparam logic [6:0] CODE_UNDERVOLT = 7'h18;
	localparam logic [6:0] CODE_RUN_TIME = 7'h1A;
	localparam logic [6:0] CODE_ZERO_SPEED = 7'h1B;
	localparam logic [6:0] CODE_LOAD_LOST = 7'h26;
	localparam logic [6:0] CODE_CUR_REACH = 7'h28;
	localparam logic [6:0] CODE_TORQ_REACH = 7'h29;
	localparam logic [6:0] CODE_SPEED_REACH = 7'h2A;
	localparam logic [6:0] CODE_SW_WORD = 7'h2F;
	localparam logic [6:0] CODE_BRAKE = 7'h43;
	localparam logic [6:0] CODE_CUTOFF = 7'h44;
	// Sequencer run modes
	localparam logic RUN_SINGLE = 1'b0;
	localparam logic RUN_LIMITED = 1'b1;
	// Overheat margins in degrees below the hot spot
	localparam logic [15:0] HEAT_ON_MARGIN = 16'h000A;
	localparam logic [15:0] HEAT_OFF_MARGIN = 16'h000F;
	// Recovery delay is counted in milliseconds
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_IN_NS = 1000000;
	localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ---- design/sfs_selector.sv ----
// Status output function selector for the open-collector and relay terminals
//
// Overview of operation
// - Code 13, single-cycle mode: output on once sequencer stops after one cycle.
// - Code 13, limited mode: output on once stopped after configured cycle count.
// - Code 13: output off otherwise, including running or sequencer status reset.
// - Code 14: output on while pulse count is at least set count.
// - Code 15: output on while pulse count is at least specified count.
// - Code 16: output on while converted length is at least set length.
// - Code 17: output on while motor current reaches overload pre-alarm coefficient.
// - Code 18: on at hot spot minus 10, off below hot spot minus 15.
// - Code 19: on while running and process feedback at least upper limit.
// - Code 20: on while running and process feedback at most lower limit.
// - Codes 21/22: on at detect level, off at level minus hysteresis, else hold.
// - Code 24: on at stall level, off after recovery level held for delay.
// - Code 26: output on when the running-time timer has expired.
// - Code 27: on in jog or run with frequency at most zero-servo start.
// - Code 38: output on while the drive is in load-lost state.
// - Code 40: output on when motor current reaches its target.
// - Code 41: output on when motor torque reaches its target.
// - Code 42: output on when motor speed reaches set frequency.
// - Code 47: each terminal follows its own bit of the software word.
// - Code 67: output on while the brake is engaged.
// - Code 68: output on when material cutoff is detected.
// - Open-collector switch is on when function valid, off when invalid.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`default_nettype none
module sfs_selector #(
	parameter int DW = 16,
	parameter int MS_CYCLES = sfs_pkg::CYC_PER_MS
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Quantities from the drive core, same clock
	input wire logic seq_stopped_i,
	input wire logic seq_status_reset_i,
	input wire logic [15:0] seq_cycles_done_i,
	input wire logic [DW-1:0] pulse_count_value_i,
	input wire logic [DW-1:0] pulse_length_value_i,
	input wire logic [DW-1:0] motor_current_i,
	input wire logic signed [DW-1:0] temperature_i,
	input wire logic signed [DW-1:0] hot_spot_i,
	input wire logic [DW-1:0] process_feedback_value_i,
	input wire logic [DW-1:0] analog_detect_one_i,
	input wire logic [DW-1:0] analog_detect_two_i,
	input wire logic [DW-1:0] bus_voltage_value_i,
	input wire logic [DW-1:0] running_time_i,
	input wire logic [DW-1:0] output_frequency_value_i,
	input wire logic [DW-1:0] set_frequency_i,
	input wire logic [DW-1:0] motor_torque_i,
	input wire logic running_i,
	input wire logic jogging_i,
	input wire logic load_lost_i,
	input wire logic brake_engaged_i,
	input wire logic material_cutoff_i,
	// Terminal drives
	output logic open_collector_output_o,
	output logic relay_output_o
);

	// Configuration registers
	logic [31:0] sel_q;
	logic [31:0] seq_q;
	logic [DW-1:0] set_count_q;
	logic [DW-1:0] spec_count_q;
	logic [DW-1:0] set_length_q;
	logic [DW-1:0] ovl_coeff_q;
	logic [DW-1:0] proc_upper_q;
	logic [DW-1:0] proc_lower_q;
	logic [31:0] adt_one_q;
	logic [31:0] adt_two_q;
	logic [DW-1:0] uv_stall_q;
	logic [DW-1:0] recovery_lvl_q;
	logic [DW-1:0] recovery_dly_q;
	logic [DW-1:0] run_time_q;
	logic [DW-1:0] zero_servo_q;
	logic [1:0] sw_word_q;
	logic [DW-1:0] cur_target_q;
	logic [DW-1:0] torq_target_q;

	// Bus response and internal state
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic heat_q;
	logic adt_one_q_st;
	logic adt_two_q_st;
	logic uv_q;
	logic [31:0] ms_cnt_q;
	logic [DW-1:0] hold_ms_q;
	logic oc_q;
	logic relay_q;

	// Hysteresis step: set wins, then clear, else keep
	function automatic logic hyst_step(input logic st, input logic set,
		input logic clr);
		hyst_step = set ? 1'b1 : (clr ? 1'b0 : st);
	endfunction

	// Map one selection code to the chosen function's validity
	function automatic logic pick(input logic [6:0] code,
		input logic [20:0] f);
		logic r;
		r = 1'b0;
		case (code)
			sfs_pkg::CODE_SEQ_DONE: r = f[0];
			sfs_pkg::CODE_SET_COUNT: r = f[1];
			sfs_pkg::CODE_SPEC_COUNT: r = f[2];
			sfs_pkg::CODE_LENGTH: r = f[3];
			sfs_pkg::CODE_OVERLOAD: r = f[4];
			sfs_pkg::CODE_OVERHEAT: r = f[5];
			sfs_pkg::CODE_PROC_HIGH: r = f[6];
			sfs_pkg::CODE_PROC_LOW: r = f[7];
			sfs_pkg::CODE_ADT_ONE: r = f[8];
			sfs_pkg::CODE_ADT_TWO: r = f[9];
			sfs_pkg::CODE_UNDERVOLT: r = f[10];
			sfs_pkg::CODE_RUN_TIME: r = f[11];
			sfs_pkg::CODE_ZERO_SPEED: r = f[12];
			sfs_pkg::CODE_LOAD_LOST: r = f[13];
			sfs_pkg::CODE_CUR_REACH: r = f[14];
			sfs_pkg::CODE_TORQ_REACH: r = f[15];
			sfs_pkg::CODE_SPEED_REACH: r = f[16];
			sfs_pkg::CODE_SW_WORD: r = f[17];
			sfs_pkg::CODE_BRAKE: r = f[18];
			sfs_pkg::CODE_CUTOFF: r = f[19];
			default: r = 1'b0;
		endcase
		pick = r;
	endfunction

	// APB decode: one wait state, write lands when pready is high
	wire acc = psel_i && penable_i;
	wire wr_en = acc && pready_q && pwrite_i && !pslverr_q;
	wire hit_sel = paddr_i == sfs_pkg::SEL_OFS;
	wire hit_seq = paddr_i == sfs_pkg::SEQ_OFS;
	wire hit_scnt = paddr_i == sfs_pkg::SET_COUNT_OFS;
	wire hit_pcnt = paddr_i == sfs_pkg::SPEC_COUNT_OFS;
	wire hit_len = paddr_i == sfs_pkg::SET_LENGTH_OFS;
	wire hit_ovl = paddr_i == sfs_pkg::OVL_COEFF_OFS;
	wire hit_pup = paddr_i == sfs_pkg::PROC_UPPER_OFS;
	wire hit_plo = paddr_i == sfs_pkg::PROC_LOWER_OFS;
	wire hit_a1 = paddr_i == sfs_pkg::ADT_ONE_OFS;
	wire hit_a2 = paddr_i == sfs_pkg::ADT_TWO_OFS;
	wire hit_uv = paddr_i == sfs_pkg::UV_STALL_OFS;
	wire hit_rl = paddr_i == sfs_pkg::RECOVERY_LVL_OFS;
	wire hit_rd = paddr_i == sfs_pkg::RECOVERY_DLY_OFS;
	wire hit_rt = paddr_i == sfs_pkg::RUN_TIME_OFS;
	wire hit_zs = paddr_i == sfs_pkg::ZERO_SERVO_OFS;
	wire hit_sw = paddr_i == sfs_pkg::SW_WORD_OFS;
	wire hit_ct = paddr_i == sfs_pkg::CUR_TARGET_OFS;
	wire hit_tt = paddr_i == sfs_pkg::TORQ_TARGET_OFS;
	wire hit_st = paddr_i == sfs_pkg::STATUS_OFS;
	wire mapped = hit_sel | hit_seq | hit_scnt | hit_pcnt | hit_len |
		hit_ovl | hit_pup | hit_plo | hit_a1 | hit_a2 | hit_uv | hit_rl |
		hit_rd | hit_rt | hit_zs | hit_sw | hit_ct | hit_tt | hit_st;

	// Read data, narrow registers sit in the low bits
	wire [31:0] status_word = {26'h000_0000, uv_q, adt_two_q_st,
		adt_one_q_st, heat_q, relay_q, oc_q};
	wire [31:0] rd_mux =
		hit_sel ? sel_q :
		hit_seq ? seq_q :
		hit_scnt ? 32'(set_count_q) :
		hit_pcnt ? 32'(spec_count_q) :
		hit_len ? 32'(set_length_q) :
		hit_ovl ? 32'(ovl_coeff_q) :
		hit_pup ? 32'(proc_upper_q) :
		hit_plo ? 32'(proc_lower_q) :
		hit_a1 ? adt_one_q :
		hit_a2 ? adt_two_q :
		hit_uv ? 32'(uv_stall_q) :
		hit_rl ? 32'(recovery_lvl_q) :
		hit_rd ? 32'(recovery_dly_q) :
		hit_rt ? 32'(run_time_q) :
		hit_zs ? 32'(zero_servo_q) :
		hit_sw ? 32'(sw_word_q) :
		hit_ct ? 32'(cur_target_q) :
		hit_tt ? 32'(torq_target_q) :
		hit_st ? status_word : 32'h0000_0000;

	// Bus handshake and read capture
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= acc && !pready_q;
			pslverr_q <= acc && !pready_q && !mapped;
			prdata_q <= (acc && !pready_q && !pwrite_i) ? rd_mux : 32'h0000_0000;
		end
	end

	// Configuration register writes
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sel_q <= sfs_pkg::CFG_RST;
			seq_q <= sfs_pkg::CFG_RST;
			set_count_q <= '0;
			spec_count_q <= '0;
			set_length_q <= '0;
			ovl_coeff_q <= '0;
			proc_upper_q <= '0;
			proc_lower_q <= '0;
			adt_one_q <= sfs_pkg::CFG_RST;
			adt_two_q <= sfs_pkg::CFG_RST;
			uv_stall_q <= '0;
			recovery_lvl_q <= '0;
			recovery_dly_q <= '0;
			run_time_q <= '0;
			zero_servo_q <= '0;
			sw_word_q <= 2'h0;
			cur_target_q <= '0;
			torq_target_q <= '0;
		end else if (wr_en) begin
			if (hit_sel) sel_q <= pwdata_i & 32'h0000_7F7F;
			if (hit_seq) seq_q <= pwdata_i & 32'hFFFF_0001;
			if (hit_scnt) set_count_q <= pwdata_i[DW-1:0];
			if (hit_pcnt) spec_count_q <= pwdata_i[DW-1:0];
			if (hit_len) set_length_q <= pwdata_i[DW-1:0];
			if (hit_ovl) ovl_coeff_q <= pwdata_i[DW-1:0];
			if (hit_pup) proc_upper_q <= pwdata_i[DW-1:0];
			if (hit_plo) proc_lower_q <= pwdata_i[DW-1:0];
			if (hit_a1) adt_one_q <= pwdata_i;
			if (hit_a2) adt_two_q <= pwdata_i;
			if (hit_uv) uv_stall_q <= pwdata_i[DW-1:0];
			if (hit_rl) recovery_lvl_q <= pwdata_i[DW-1:0];
			if (hit_rd) recovery_dly_q <= pwdata_i[DW-1:0];
			if (hit_rt) run_time_q <= pwdata_i[DW-1:0];
			if (hit_zs) zero_servo_q <= pwdata_i[DW-1:0];
			if (hit_sw) sw_word_q <= pwdata_i[1:0];
			if (hit_ct) cur_target_q <= pwdata_i[DW-1:0];
			if (hit_tt) torq_target_q <= pwdata_i[DW-1:0];
		end
	end

	// Sequencer completion, gated off by a status reset
	wire seq_mode = seq_q[0];
	wire [15:0] seq_limit = seq_q[sfs_pkg::SEQ_LIMIT_LSB +: 16];
	wire seq_one = seq_mode == sfs_pkg::RUN_SINGLE &&
		seq_cycles_done_i != 16'h0000;
	wire seq_lim = seq_mode == sfs_pkg::RUN_LIMITED &&
		seq_cycles_done_i >= seq_limit;
	wire f_seq = seq_stopped_i && !seq_status_reset_i &&
		(seq_one || seq_lim);

	// Plain threshold comparisons
	wire f_scnt = pulse_count_value_i >= set_count_q;
	wire f_pcnt = pulse_count_value_i >= spec_count_q;
	wire f_len = pulse_length_value_i >= set_length_q;
	wire f_ovl = motor_current_i >= ovl_coeff_q;
	wire f_phi = running_i &&
		process_feedback_value_i >= proc_upper_q;
	wire f_plo = running_i &&
		process_feedback_value_i <= proc_lower_q;
	wire f_rt = running_time_i >= run_time_q;
	wire f_zero = (jogging_i || running_i) &&
		output_frequency_value_i <= zero_servo_q;
	wire f_cur = motor_current_i >= cur_target_q;
	wire f_torq = motor_torque_i >= torq_target_q;
	wire f_spd = output_frequency_value_i == set_frequency_i;

	// Overheat thresholds, widened so the subtraction cannot wrap
	wire signed [DW:0] hot_ext = {hot_spot_i[DW-1], hot_spot_i};
	wire signed [DW:0] temp_ext = {temperature_i[DW-1], temperature_i};
	wire signed [DW:0] heat_on = hot_ext -
		$signed({1'b0, sfs_pkg::HEAT_ON_MARGIN[DW-1:0]});
	wire signed [DW:0] heat_off = hot_ext -
		$signed({1'b0, sfs_pkg::HEAT_OFF_MARGIN[DW-1:0]});
	wire heat_set = temp_ext >= heat_on;
	wire heat_clr = temp_ext < heat_off;

	// Analog detection thresholds, no clear if hysteresis exceeds level
	wire [DW-1:0] a1_lvl = adt_one_q[DW-1:0];
	wire [DW-1:0] a1_hys = adt_one_q[sfs_pkg::HYST_LSB +: DW];
	wire [DW-1:0] a2_lvl = adt_two_q[DW-1:0];
	wire [DW-1:0] a2_hys = adt_two_q[sfs_pkg::HYST_LSB +: DW];
	wire [DW:0] a1_low = {1'b0, a1_lvl} - {1'b0, a1_hys};
	wire [DW:0] a2_low = {1'b0, a2_lvl} - {1'b0, a2_hys};
	wire a1_set = analog_detect_one_i >= a1_lvl;
	wire a2_set = analog_detect_two_i >= a2_lvl;
	wire a1_clr = !a1_low[DW] && analog_detect_one_i <= a1_low[DW-1:0];
	wire a2_clr = !a2_low[DW] && analog_detect_two_i <= a2_low[DW-1:0];

	// Undervoltage detection and recovery timing
	wire uv_set = bus_voltage_value_i <= uv_stall_q;
	wire uv_ok = bus_voltage_value_i >= recovery_lvl_q;
	wire ms_tick = ms_cnt_q == 32'(MS_CYCLES - 1);
	wire uv_done = uv_ok && hold_ms_q >= recovery_dly_q;

	// Hysteresis flags hold between their thresholds
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			heat_q <= 1'b0;
			adt_one_q_st <= 1'b0;
			adt_two_q_st <= 1'b0;
		end else begin
			heat_q <= hyst_step(heat_q, heat_set, heat_clr);
			adt_one_q_st <= hyst_step(adt_one_q_st, a1_set, a1_clr);
			adt_two_q_st <= hyst_step(adt_two_q_st, a2_set, a2_clr);
		end
	end

	// Recovery hold time in milliseconds, restarted on any dip
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ms_cnt_q <= 32'h0000_0000;
			hold_ms_q <= '0;
		end else if (!uv_ok || !uv_q) begin
			ms_cnt_q <= 32'h0000_0000;
			hold_ms_q <= '0;
		end else begin
			ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
			if (ms_tick && hold_ms_q != '1) hold_ms_q <= hold_ms_q + 1'b1;
		end
	end

	// Undervoltage flag: stall level sets, held recovery clears
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			uv_q <= 1'b0;
		end else begin
			uv_q <= hyst_step(uv_q, uv_set, uv_done);
		end
	end

	// Function vector shared by both terminals
	wire [20:0] f_common = {1'b0, material_cutoff_i,
		brake_engaged_i,
		1'b0, f_spd, f_torq, f_cur,
		load_lost_i,
		f_zero, f_rt, uv_q, adt_two_q_st, adt_one_q_st, f_plo, f_phi,
		heat_q, f_ovl, f_len, f_pcnt, f_scnt, f_seq};
	wire [20:0] f_oc = f_common |
		{3'h0, sw_word_q[sfs_pkg::SW_OC_BIT], 17'h0_0000};
	wire [20:0] f_rly = f_common |
		{3'h0, sw_word_q[sfs_pkg::SW_RLY_BIT], 17'h0_0000};
	wire [6:0] oc_code = sel_q[sfs_pkg::SEL_OC_LSB +: sfs_pkg::SEL_W];
	wire [6:0] rly_code = sel_q[sfs_pkg::SEL_RLY_LSB +: sfs_pkg::SEL_W];
	wire oc_valid = pick(oc_code, f_oc);
	wire rly_valid = pick(rly_code, f_rly);

	// Terminal drives registered
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			oc_q <= 1'b0;
			relay_q <= 1'b0;
		end else begin
			oc_q <= oc_valid;
			relay_q <= rly_valid;
		end
	end

	// Output ports straight from flip-flops
	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign open_collector_output_o = oc_q;
	assign relay_output_o = relay_q;

endmodule
`default_nettype wire

// ---- tb/sfs_selector_monitor.sv ----
// Checker of bus timing and terminal functions of the selector
`default_nettype none
module sfs_selector_monitor #(
	parameter int DW = 16
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [DW-1:0] pulse_count_value_i,
	input wire logic load_lost_i,
	input wire logic brake_engaged_i,
	input wire logic material_cutoff_i,
	input wire logic open_collector_output_o,
	input wire logic relay_output_o
);
	timeunit 1ns / 1ps;
	logic [6:0] oc_q, rl_q;
	logic swr_q;
	logic [DW-1:0] cnt_q;
	logic wr, oc, rl;
	// Completed writes and short names for the terminals
	assign wr = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
	assign oc = open_collector_output_o;
	assign rl = relay_output_o;
	// Shadow of selection, relay software bit and set count
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			oc_q <= 7'h00;
			rl_q <= 7'h00;
			swr_q <= 1'b0;
			cnt_q <= '0;
		end else if (wr) begin
			if (paddr_i == sfs_pkg::SEL_OFS) begin
				oc_q <= pwdata_i[6:0];
				rl_q <= pwdata_i[14:8];
			end
			if (paddr_i == sfs_pkg::SW_WORD_OFS)
				swr_q <= pwdata_i[1];
			if (paddr_i == sfs_pkg::SET_COUNT_OFS)
				cnt_q <= pwdata_i[DW-1:0];
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	chk_ready_wait: assert property ($rose(penable_i) && psel_i |=> pready_o)
		else $error("no ready after one wait state");
	chk_ready_once: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	chk_unmapped_err: assert property (
		pready_o && paddr_i > sfs_pkg::STATUS_OFS |-> pslverr_o)
		else $error("unmapped access without error");
	chk_brake_oc: assert property (
		oc_q == sfs_pkg::CODE_BRAKE |=> oc == $past(brake_engaged_i))
		else $error("switch not following brake");
	chk_lost_oc: assert property (
		oc_q == sfs_pkg::CODE_LOAD_LOST |=> oc == $past(load_lost_i))
		else $error("switch not following load loss");
	chk_count_oc: assert property (
		oc_q == sfs_pkg::CODE_SET_COUNT |=>
		oc == ($past(pulse_count_value_i) >= $past(cnt_q)))
		else $error("switch wrong for set count");
	chk_idle_oc: assert property (
		oc_q == 7'h00 || oc_q == 7'h1E |=> !oc)
		else $error("switch on for unassigned code");
	chk_cutoff_rly: assert property (
		rl_q == sfs_pkg::CODE_CUTOFF |=> rl == $past(material_cutoff_i))
		else $error("relay not following cutoff");
	chk_word_rly: assert property (
		rl_q == sfs_pkg::CODE_SW_WORD |=> rl == $past(swr_q))
		else $error("relay not following software bit");
endmodule

bind sfs_selector sfs_selector_monitor #(.DW(DW)) mon_u (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.pulse_count_value_i(pulse_count_value_i), .load_lost_i(load_lost_i),
	.brake_engaged_i(brake_engaged_i),
	.material_cutoff_i(material_cutoff_i),
	.open_collector_output_o(open_collector_output_o),
	.relay_output_o(relay_output_o)
);
`default_nettype wire

// ---- tb/sfs_term_load.sv ----
// Terminal load: pulled-up open-collector line and relay contact
`default_nettype none
module sfs_term_load (
	input wire logic sw_on_i,
	input wire logic coil_i,
	output logic oc_line_o,
	output logic contact_o
);
	timeunit 1ns / 1ps;
	// Pull-up lifts the line while the switch is off
	assign oc_line_o = sw_on_i ? 1'b0 : 1'b1;
	// Energised coil closes the normally open contact
	assign contact_o = coil_i;
endmodule
`default_nettype wire

// ---- tb/status_output_function_selector_tb_top.sv ----
// Self-checking bench of the status output function selector
`default_nettype none
module status_output_function_selector_tb_top;
	timeunit 1ns / 1ps;
	localparam logic [7:0] CFO [10] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
		8'h1C, 8'h34, 8'h38, 8'h40, 8'h44};
	localparam logic [6:0] CODES [17] = '{7'h0E, 7'h0F, 7'h10, 7'h11, 7'h13,
		7'h14, 7'h1A, 7'h1B, 7'h26, 7'h28, 7'h29, 7'h2A, 7'h2F, 7'h43, 7'h44,
		7'h1E, 7'h00};
	localparam logic signed [15:0] HT [6] = '{16'sh0054, 16'sh005A,
		16'sh0056, 16'sh0055, 16'sh0054, 16'sh0059};
	localparam logic [15:0] HA [6] = '{16'h0384, 16'h03E8, 16'h03B6,
		16'h0385, 16'h0384, 16'h03B6};
	localparam logic [7:0] SQ [5] = '{8'h51, 8'h01, 8'h61, 8'hC2, 8'hD3};
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, err_s;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_s;
	logic seq_stop, seq_rst, run, jog, lost, brake, cutoff;
	logic [15:0] seq_done, pcnt, plen, mcur, fb, analog_detect_one, analog_detect_two, vbus, rtime;
	logic [15:0] ofreq, sfreq, torq;
	logic [15:0] cfg [10];
	logic signed [15:0] temp, hot;
	logic oc, rly, oc_line, contact, e0, e1;
	logic [1:0] sw;
	int n_fail, num_checks;

	sfs_selector #(.DW(16), .MS_CYCLES(4)) dut_u (
		.clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.seq_stopped_i(seq_stop), .seq_status_reset_i(seq_rst),
		.seq_cycles_done_i(seq_done), .pulse_count_value_i(pcnt),
		.pulse_length_value_i(plen), .motor_current_i(mcur),
		.temperature_i(temp), .hot_spot_i(hot),
		.process_feedback_value_i(fb), .analog_detect_one_i(analog_detect_one),
		.analog_detect_two_i(analog_detect_two), .bus_voltage_value_i(vbus),
		.running_time_i(rtime), .output_frequency_value_i(ofreq),
		.set_frequency_i(sfreq), .motor_torque_i(torq), .running_i(run),
		.jogging_i(jog), .load_lost_i(lost), .brake_engaged_i(brake),
		.material_cutoff_i(cutoff), .open_collector_output_o(oc),
		.relay_output_o(rly)
	);
	sfs_term_load load_u (.sw_on_i(oc), .coil_i(rly), .oc_line_o(oc_line),
		.contact_o(contact));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One APB transfer, waiting a bounded time for ready
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd_s = prdata;
		err_s = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 16) begin
			n_fail++;
			finish_test();
		end
	endtask

	// Let the terminals settle, then check switch, line and contact
	task automatic step(input logic eo, input logic er);
		repeat (3) @(posedge clk);
		chk(32'(oc), 32'(eo));
		chk(32'(oc_line), 32'(!eo));
		chk(32'(contact), 32'(er));
	endtask

	// Small random quantities so that thresholds are often met exactly
	task automatic rand_in();
		pcnt <= 16'($urandom_range(0, 7));
		plen <= 16'($urandom_range(0, 7));
		mcur <= 16'($urandom_range(0, 7));
		fb <= 16'($urandom_range(0, 7));
		rtime <= 16'($urandom_range(0, 7));
		ofreq <= 16'($urandom_range(0, 7));
		sfreq <= 16'($urandom_range(0, 7));
		torq <= 16'($urandom_range(0, 7));
		{run, jog, lost, brake, cutoff} <= 5'($urandom);
	endtask

	// Expected terminal state for the stateless codes other than 13
	function automatic logic fexp(input logic [6:0] c, input int t);
		case (c)
			sfs_pkg::CODE_SET_COUNT: return pcnt >= cfg[0];
			sfs_pkg::CODE_SPEC_COUNT: return pcnt >= cfg[1];
			sfs_pkg::CODE_LENGTH: return plen >= cfg[2];
			sfs_pkg::CODE_OVERLOAD: return mcur >= cfg[3];
			sfs_pkg::CODE_PROC_HIGH: return run && fb >= cfg[4];
			sfs_pkg::CODE_PROC_LOW: return run && fb <= cfg[5];
			sfs_pkg::CODE_RUN_TIME: return rtime >= cfg[6];
			sfs_pkg::CODE_ZERO_SPEED: return (run || jog) && ofreq <= cfg[7];
			sfs_pkg::CODE_LOAD_LOST: return lost;
			sfs_pkg::CODE_CUR_REACH: return mcur >= cfg[8];
			sfs_pkg::CODE_TORQ_REACH: return torq >= cfg[9];
			sfs_pkg::CODE_SPEED_REACH: return ofreq == sfreq;
			sfs_pkg::CODE_SW_WORD: return sw[t];
			sfs_pkg::CODE_BRAKE: return brake;
			sfs_pkg::CODE_CUTOFF: return cutoff;
			default: return 1'b0;
		endcase
	endfunction

	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, seq_stop, seq_rst} = '0;
		{seq_done, pcnt, plen, mcur, fb, analog_detect_one, analog_detect_two, vbus, rtime} = '0;
		{ofreq, sfreq, torq, temp, hot, run, jog, lost, brake, cutoff} = '0;
		{n_fail, num_checks, sw} = '0;
		arst_n = 1'b0;
		void'($urandom(84));
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		// Reset state, read-back and an unmapped place
		step(1'b0, 1'b0);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd_s, 32'h0);
		apb(1'b1, 8'h00, 32'h0000_1E2F);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd_s, 32'h0000_1E2F);
		apb(1'b0, 8'h4C, 32'h0);
		chk({rd_s[30:0], err_s}, 32'h1);
		$display("test bus done");
		// Every stateless code except 13 on both terminals with random inputs
		for (int i = 0; i < 10; i++) begin
			cfg[i] = 16'($urandom_range(0, 7));
			apb(1'b1, CFO[i], {16'h0, cfg[i]});
		end
		for (int i = 0; i < 17; i++) begin
			apb(1'b1, 8'h00, {17'h0, CODES[(i + 1) % 17], 1'b0, CODES[i]});
			for (int k = 0; k < 6; k++) begin
				sw = 2'($urandom);
				apb(1'b1, 8'h3C, {30'h0, sw});
				rand_in();
				@(posedge clk);
				e0 = fexp(CODES[i], 0);
				e1 = fexp(CODES[(i + 1) % 17], 1);
				repeat (3) @(posedge clk);
				chk(32'(oc), 32'(e0));
				chk(32'(rly), 32'(e1));
			end
		end
		$display("test codes done");
		// Overheat and analog detection with hysteresis, swapped per pass
		apb(1'b1, 8'h20, 32'h0064_03E8);
		apb(1'b1, 8'h24, 32'h0064_03E8);
		hot <= 16'sh0064;
		for (int p = 0; p < 2; p++) begin
			apb(1'b1, 8'h00, p == 0 ? 32'h0000_1512 : 32'h0000_1216);
			for (int k = 0; k < 6; k++) begin
				temp <= HT[k];
				analog_detect_one <= HA[k];
				analog_detect_two <= HA[k];
				step(k >= 1 && k <= 3, k >= 1 && k <= 3);
			end
		end
		$display("test hysteresis done");
		// Undervoltage with a three millisecond recovery hold
		apb(1'b1, 8'h28, 32'h0000_012C);
		apb(1'b1, 8'h2C, 32'h0000_0190);
		apb(1'b1, 8'h30, 32'h0000_0003);
		apb(1'b1, 8'h00, 32'h0000_1818);
		vbus <= 16'h0122;
		step(1'b1, 1'b1);
		vbus <= 16'h01C2;
		step(1'b1, 1'b1);
		step(1'b1, 1'b1);
		repeat (12) @(posedge clk);
		step(1'b0, 1'b0);
		vbus <= 16'h015E;
		step(1'b0, 1'b0);
		vbus <= 16'h012C;
		step(1'b1, 1'b1);
		$display("test undervoltage done");
		// Sequencer completion in both run modes, relay unassigned
		apb(1'b1, 8'h00, 32'h0000_000D);
		for (int k = 0; k < 5; k++) begin
			apb(1'b1, 8'h04, {16'h0003, 15'h0, SQ[k][7]});
			seq_stop <= SQ[k][6];
			seq_rst <= SQ[k][5];
			seq_done <= {12'h0, SQ[k][3:0]};
			step(SQ[k][4], 1'b0);
		end
		$display("test sequencer done");
		finish_test();
	end
endmodule
`default_nettype wire
